// ==== rucio_pkg.sv ====
// constants shared by the remote user control block
package rucio_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned SYNC_PULSE_MS  = 10;
	localparam int unsigned SYNC_PULSE_CYC = CLK_HZ / 1000 * SYNC_PULSE_MS;
	localparam int unsigned FILT_TIME_US   = 20;
	localparam int unsigned FILT_CYC       = CLK_HZ / 1_000_000 * FILT_TIME_US;
	localparam int unsigned NUM_CH_DEF     = 3;
	localparam int unsigned ADDR_W         = 8;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_CMD      = 8'h04;
	localparam logic [7:0] OFF_STATUS   = 8'h08;
	localparam logic [7:0] OFF_INT_STAT = 8'h0c;
	localparam logic [7:0] OFF_INT_MASK = 8'h10;

	// field positions, one byte lane per field, bit n of a lane is channel n
	localparam int unsigned FLD_W    = 8;
	localparam int unsigned FLD_LANE0 = 0;
	localparam int unsigned FLD_LANE1 = 8;
	localparam int unsigned FLD_LANE2 = 16;
	localparam int unsigned FLD_LANE3 = 24;

	// reset values
	localparam logic [7:0]  CTRL_EN_RST  = 8'hff;
	localparam logic [31:0] INT_MASK_RST = 32'h0000_0000;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rucio_in_filt.sv ====
// two-stage synchroniser and stability filter for external inputs
module rucio_in_filt
	import rucio_pkg::*;
#(
	parameter int unsigned W    = 3,
	parameter int unsigned FLEN = FILT_CYC
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] din_i,
	output logic      [W-1:0] dout_o
);
	localparam int unsigned FW = $clog2(FLEN + 1);
	localparam logic [FW-1:0] FLAST = FW'(FLEN - 1);

	typedef struct packed {
		logic [W-1:0]         sync1;
		logic [W-1:0]         sync2;
		logic [W-1:0]         flt;
		logic [W-1:0][FW-1:0] cnt;
	} rucio_filt_t;

	rucio_filt_t s;
	rucio_filt_t n;

	// sync1 feeds only sync2; the filter looks at sync2 alone
	always_comb begin
		n       = s;
		n.sync1 = din_i;
		n.sync2 = s.sync1;
		for (int i = 0; i < W; i++) begin
			if (s.sync2[i] == s.flt[i]) begin
				n.cnt[i] = '0;
			end else if (s.cnt[i] == FLAST) begin
				n.flt[i] = s.sync2[i];
				n.cnt[i] = '0;
			end else begin
				n.cnt[i] = s.cnt[i] + FW'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= n;
		end
	end

	assign dout_o = s.flt;
endmodule // rucio_in_filt

// ==== rucio_top.sv ====
// rear-panel remote on/off, inhibit, trigger and status logic with register access
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
module rucio_top
	import rucio_pkg::*;
#(
	parameter int unsigned NCH      = NUM_CH_DEF,
	parameter int unsigned PULSE_LEN = SYNC_PULSE_CYC,
	parameter int unsigned FILT_LEN = FILT_CYC
) (
	input  wire logic              SYS_CLK_I,
	input  wire logic              RST_I,
	input  wire logic              CE_I,
	// external pins
	input  wire logic [NCH-1:0]    CHAN_OUTPUT_ENABLE_I,
	input  wire logic [NCH-1:0]    CHAN_INHIBIT_CLOSED_I,
	input  wire logic [NCH-1:0]    CHAN_TRIGGER_I,
	output logic      [NCH-1:0]    CHAN_SYNC_PULSE_O,
	output logic      [NCH-1:0]    CHAN_REGULATION_MODE_O,
	output logic      [NCH-1:0]    CHAN_OUTPUT_ON_O,
	output logic      [NCH-1:0]    CHAN_FAULT_LINE_O,
	// internal supply logic, same clock
	input  wire logic [NCH-1:0]    CHAN_CC_MODE_I,
	input  wire logic [NCH-1:0]    CHAN_FAULT_I,
	output logic      [NCH-1:0]    CHAN_TRIGGER_EVENT_O,
	output logic                   IRQ_O,
	// register bus
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input  wire logic              S_AXI_AWVALID_I,
	output logic                   S_AXI_AWREADY_O,
	input  wire logic [31:0]       S_AXI_WDATA_I,
	input  wire logic [3:0]        S_AXI_WSTRB_I,
	input  wire logic              S_AXI_WVALID_I,
	output logic                   S_AXI_WREADY_O,
	output logic [1:0]             S_AXI_BRESP_O,
	output logic                   S_AXI_BVALID_O,
	input  wire logic              S_AXI_BREADY_I,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input  wire logic              S_AXI_ARVALID_I,
	output logic                   S_AXI_ARREADY_O,
	output logic [31:0]            S_AXI_RDATA_O,
	output logic [1:0]             S_AXI_RRESP_O,
	output logic                   S_AXI_RVALID_O,
	input  wire logic              S_AXI_RREADY_I
);
	localparam int unsigned CW = $clog2(PULSE_LEN + 1);
	localparam logic [CW-1:0] PLAST = CW'(PULSE_LEN - 1);
	localparam logic [31:0] LANE_MASK = 32'((64'h1 << NCH) - 64'h1);
	localparam logic [31:0] INT_VALID = (LANE_MASK << FLD_LANE0) | (LANE_MASK << FLD_LANE1)
		| (LANE_MASK << FLD_LANE2);

	typedef struct packed {
		logic                 awready;
		logic                 wready;
		logic                 aw_got;
		logic                 w_got;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic [ADDR_W-1:0]    waddr;
		logic [31:0]          wdata;
		logic [3:0]           wstrb;
		logic                 arready;
		logic                 rvalid;
		logic [1:0]           rresp;
		logic [31:0]          rdata;
		logic [NCH-1:0]       ctrl_en;
		logic [31:0]          int_stat;
		logic [31:0]          int_mask;
		logic                 irq;
		logic [NCH-1:0]       en_q;
		logic [NCH-1:0]       trg_q;
		logic [NCH-1:0]       flt_q;
		logic [NCH-1:0]       latch;
		logic [NCH-1:0]       out_on;
		logic [NCH-1:0]       sync;
		logic [NCH-1:0][CW-1:0] cnt;
		logic [NCH-1:0]       trig_evt;
		logic [NCH-1:0]       cc;
		logic [NCH-1:0]       fault;
	} rucio_state_t;

	rucio_state_t s_r;
	rucio_state_t s_nxt;

	logic [3*NCH-1:0] pins_flt;
	logic [NCH-1:0]   en_f;
	logic [NCH-1:0]   inh_f;
	logic [NCH-1:0]   trg_f;

	// pins are asynchronous to the control clock
	rucio_in_filt #(
		.W    (3 * NCH),
		.FLEN (FILT_LEN)
	) u_filt (
		.clk_i  (SYS_CLK_I),
		.rst_i  (RST_I),
		.ce_i   (CE_I),
		.din_i  ({CHAN_TRIGGER_I, CHAN_INHIBIT_CLOSED_I, CHAN_OUTPUT_ENABLE_I}),
		.dout_o (pins_flt)
	);

	assign en_f  = pins_flt[NCH-1:0];
	assign inh_f = pins_flt[2*NCH-1:NCH];
	assign trg_f = pins_flt[3*NCH-1:2*NCH];

	// byte-lane merge for partial writes
	function automatic logic [31:0] rucio_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// next-state logic: bus slave, channel control, interrupts
	always_comb begin
		logic [NCH-1:0] cmd_on;
		logic [31:0]    int_set;
		logic [31:0]    int_clr;
		logic [31:0]    wd;
		logic [31:0]    status_w;
		logic [31:0]    ctrl_w;
		logic           turn_on;
		logic           on;
		cmd_on   = '0;
		int_set  = '0;
		int_clr  = '0;
		wd       = '0;
		status_w = '0;
		ctrl_w   = '0;
		turn_on  = 1'b0;
		on       = 1'b0;
		s_nxt    = s_r;
		s_nxt.trig_evt = '0;

		// write channel: address and data accepted in either order
		if (S_AXI_AWVALID_I && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.waddr  = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = S_AXI_WDATA_I;
			s_nxt.wstrb = S_AXI_WSTRB_I;
		end
		if (s_r.bvalid && S_AXI_BREADY_I) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = RESP_OKAY;
			ctrl_w = 32'(s_r.ctrl_en);
			unique case (s_r.waddr)
				OFF_CTRL: begin
					wd = rucio_merge(ctrl_w, s_r.wdata, s_r.wstrb);
					s_nxt.ctrl_en = wd[NCH-1:0];
				end
				OFF_CMD: begin
					// write-one pulse, the user's fresh turn-on command
					wd = rucio_merge(32'h0000_0000, s_r.wdata, s_r.wstrb);
					cmd_on = wd[NCH-1:0];
				end
				OFF_INT_MASK: begin
					wd = rucio_merge(s_r.int_mask, s_r.wdata, s_r.wstrb);
					s_nxt.int_mask = wd & INT_VALID;
				end
				OFF_STATUS, OFF_INT_STAT: begin
					s_nxt.bresp = RESP_OKAY; // read-only, write ignored
				end
				default: begin
					s_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

		// read channel, one outstanding read
		status_w[FLD_LANE0 +: NCH] = s_r.out_on;
		status_w[FLD_LANE1 +: NCH] = s_r.latch;
		status_w[FLD_LANE2 +: NCH] = s_r.cc;
		status_w[FLD_LANE3 +: NCH] = s_r.fault;
		if (s_r.rvalid && S_AXI_RREADY_I) begin
			s_nxt.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID_I && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = RESP_OKAY;
			unique case (S_AXI_ARADDR_I)
				OFF_CTRL:     s_nxt.rdata = 32'(s_r.ctrl_en);
				OFF_CMD:      s_nxt.rdata = 32'h0000_0000;
				OFF_STATUS:   s_nxt.rdata = status_w;
				OFF_INT_STAT: begin
					s_nxt.rdata = s_r.int_stat;
					int_clr     = s_r.int_stat; // read clears what was returned
				end
				OFF_INT_MASK: s_nxt.rdata = s_r.int_mask;
				default: begin
					s_nxt.rdata = 32'h0000_0000;
					s_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		s_nxt.arready = !s_nxt.rvalid;

		// per-channel output control
		for (int c = 0; c < NCH; c++) begin
			s_nxt.en_q[c]  = en_f[c];
			s_nxt.trg_q[c] = trg_f[c];
			// edge of the on/off input or a software command counts as fresh turn-on
			turn_on = (en_f[c] && !s_r.en_q[c]) || cmd_on[c];
			if (!inh_f[c]) begin
				s_nxt.latch[c] = 1'b1;
			end else if (turn_on) begin
				s_nxt.latch[c] = 1'b0;
			end
			if (s_nxt.latch[c] && !s_r.latch[c]) begin
				int_set[FLD_LANE1 + c] = 1'b1;
			end
			// on only with valid high level, contact closed, not latched and enabled
			on = en_f[c] && inh_f[c] && !s_nxt.latch[c] && s_r.ctrl_en[c];
			s_nxt.out_on[c] = on;

			// restart on every change so back-to-back changes stretch the pulse
			if (on != s_r.out_on[c]) begin
				s_nxt.cnt[c]  = PLAST;
				s_nxt.sync[c] = 1'b1;
			end else if (s_r.cnt[c] != '0) begin
				s_nxt.cnt[c] = s_r.cnt[c] - CW'(1);
			end else begin
				s_nxt.sync[c] = 1'b0;
			end

			// one event per rising edge of the filtered trigger
			if (trg_f[c] && !s_r.trg_q[c]) begin
				s_nxt.trig_evt[c] = 1'b1;
				int_set[FLD_LANE0 + c] = 1'b1;
			end

			// status from the regulation loop and fault monitor
			s_nxt.cc[c]    = CHAN_CC_MODE_I[c];
			s_nxt.fault[c] = CHAN_FAULT_I[c];
			s_nxt.flt_q[c] = CHAN_FAULT_I[c];
			if (CHAN_FAULT_I[c] && !s_r.flt_q[c]) begin
				int_set[FLD_LANE2 + c] = 1'b1;
			end
		end

		// sticky status: a new event wins over a read clear in the same cycle
		s_nxt.int_stat = ((s_r.int_stat & ~int_clr) | int_set) & INT_VALID;
		s_nxt.irq      = |(s_nxt.int_stat & s_nxt.int_mask);
	end

	// single state register; clock enable freezes everything
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			s_r          <= '0;
			s_r.awready  <= 1'b1;
			s_r.wready   <= 1'b1;
			s_r.arready  <= 1'b1;
			s_r.ctrl_en  <= CTRL_EN_RST[NCH-1:0];
			s_r.int_mask <= INT_MASK_RST;
			s_r.latch    <= '1; // output stays off until a first turn-on
		end else if (CE_I) begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign CHAN_SYNC_PULSE_O      = s_r.sync;
	assign CHAN_REGULATION_MODE_O = s_r.cc;
	assign CHAN_OUTPUT_ON_O       = s_r.out_on;
	assign CHAN_FAULT_LINE_O      = s_r.fault;
	assign CHAN_TRIGGER_EVENT_O   = s_r.trig_evt;
	assign IRQ_O                  = s_r.irq;
	assign S_AXI_AWREADY_O        = s_r.awready;
	assign S_AXI_WREADY_O         = s_r.wready;
	assign S_AXI_BRESP_O          = s_r.bresp;
	assign S_AXI_BVALID_O         = s_r.bvalid;
	assign S_AXI_ARREADY_O        = s_r.arready;
	assign S_AXI_RDATA_O          = s_r.rdata;
	assign S_AXI_RRESP_O          = s_r.rresp;
	assign S_AXI_RVALID_O         = s_r.rvalid;
endmodule // rucio_top

// ==== rucio_ext_ctrl.sv ====
// behavioural model of the external controller and relay contacts
module rucio_ext_ctrl #(
	parameter int unsigned NCH = 3
) (
	input  wire logic           clk_i,
	input  wire logic [NCH-1:0] en_req_i,
	input  wire logic [NCH-1:0] inh_req_i,
	input  wire logic [NCH-1:0] trg_req_i,
	input  wire logic           glitch_i,
	output logic      [NCH-1:0] en_o,
	output logic      [NCH-1:0] inh_o,
	output logic      [NCH-1:0] trg_o
);
	// pins idle low until the first edge
	initial {en_o, inh_o, trg_o} = '0;
	// pins move just after the edge; glitch is a one-cycle bounce on the trigger wires
	always @(posedge clk_i) begin
		en_o <= en_req_i;
		inh_o <= inh_req_i;
		trg_o <= trg_req_i ^ {NCH{glitch_i}};
	end
endmodule // rucio_ext_ctrl

// ==== rucio_top_asserts.sv ====
// concurrent checks on the rear-panel pins of the top module
module rucio_top_asserts #(
	parameter int unsigned NCH       = 3,
	parameter int unsigned PULSE_LEN = 20,
	parameter int unsigned FILT_LEN  = 3
) (
	input wire logic           SYS_CLK_I,
	input wire logic           RST_I,
	input wire logic           CE_I,
	input wire logic [NCH-1:0] CHAN_OUTPUT_ENABLE_I,
	input wire logic [NCH-1:0] CHAN_INHIBIT_CLOSED_I,
	input wire logic [NCH-1:0] CHAN_TRIGGER_I,
	input wire logic [NCH-1:0] CHAN_SYNC_PULSE_O,
	input wire logic [NCH-1:0] CHAN_REGULATION_MODE_O,
	input wire logic [NCH-1:0] CHAN_OUTPUT_ON_O,
	input wire logic [NCH-1:0] CHAN_FAULT_LINE_O,
	input wire logic [NCH-1:0] CHAN_CC_MODE_I,
	input wire logic [NCH-1:0] CHAN_FAULT_I,
	input wire logic [NCH-1:0] CHAN_TRIGGER_EVENT_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);
	logic        on_q_r;
	int unsigned since_r;
	int unsigned en_low_r;
	int unsigned inh_open_r;
	// cycles since channel 0 output moved; saturates so it never wraps
	always_ff @(posedge SYS_CLK_I) begin
		on_q_r <= CHAN_OUTPUT_ON_O[0];
		if (RST_I)
			since_r <= PULSE_LEN;
		else if (CHAN_OUTPUT_ON_O[0] != on_q_r)
			since_r <= 1;
		else if (CE_I && since_r < PULSE_LEN)
			since_r <= since_r + 1;
	end
	// enabled cycles a pin has stood low; sync flops and filter only move while enabled
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I || CHAN_OUTPUT_ENABLE_I[0])
			en_low_r <= 0;
		else if (CE_I && en_low_r < FILT_LEN + 3)
			en_low_r <= en_low_r + 1;
		if (RST_I || CHAN_INHIBIT_CLOSED_I[0])
			inh_open_r <= 0;
		else if (CE_I && inh_open_r < FILT_LEN + 3)
			inh_open_r <= inh_open_r + 1;
	end
	// two sync edges, the filter run and the output flop have all passed
	sequence s_en_low;
		en_low_r >= FILT_LEN + 3;
	endsequence
	sequence s_inh_open;
		inh_open_r >= FILT_LEN + 3;
	endsequence
	AST_REG_MODE: assert property (!$past(RST_I) && $past(CE_I) |-> CHAN_REGULATION_MODE_O == $past(CHAN_CC_MODE_I))
		else $error("regulation mode lags wrongly");
	AST_FAULT: assert property (!$past(RST_I) && $past(CE_I) |-> CHAN_FAULT_LINE_O == $past(CHAN_FAULT_I))
		else $error("fault line lags wrongly");
	AST_SYNC_LEN: assert property (CHAN_SYNC_PULSE_O[0] == (CHAN_OUTPUT_ON_O[0] != on_q_r || since_r < PULSE_LEN))
		else $error("sync pulse length wrong");
	AST_EN_OFF: assert property (s_en_low |-> !CHAN_OUTPUT_ON_O[0])
		else $error("output on with on/off input low");
	AST_INH_OFF: assert property (s_inh_open |-> !CHAN_OUTPUT_ON_O[0])
		else $error("output on with inhibit open");
	AST_ON_CAUSE: assert property ($rose(CHAN_OUTPUT_ON_O[0]) |-> $past(CHAN_OUTPUT_ENABLE_I[0] && CHAN_INHIBIT_CLOSED_I[0], 4))
		else $error("output on without enable and inhibit closed");
	AST_TRIG_ONE: assert property (CHAN_TRIGGER_EVENT_O[0] |=> !CHAN_TRIGGER_EVENT_O[0])
		else $error("trigger event longer than one cycle");
	AST_TRIG_CAUSE: assert property (CHAN_TRIGGER_EVENT_O[0] |-> $past(CHAN_TRIGGER_I[0], 3))
		else $error("trigger event without trigger input");
endmodule // rucio_top_asserts
bind rucio_top rucio_top_asserts #(.NCH(NCH), .PULSE_LEN(PULSE_LEN), .FILT_LEN(FILT_LEN)) i_rucio_top_asserts (
	.SYS_CLK_I, .RST_I, .CE_I,
	.CHAN_OUTPUT_ENABLE_I, .CHAN_INHIBIT_CLOSED_I, .CHAN_TRIGGER_I, .CHAN_SYNC_PULSE_O, .CHAN_REGULATION_MODE_O,
	.CHAN_OUTPUT_ON_O, .CHAN_FAULT_LINE_O, .CHAN_CC_MODE_I, .CHAN_FAULT_I, .CHAN_TRIGGER_EVENT_O);

// ==== rucio_top_tb_top.sv ====
// self-checking bench for the remote user control block
module rucio_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rucio_pkg::*;
	localparam int unsigned PL = 20;
	logic        clk = 1'b0, rst = 1'b1, glitch = 1'b0, ce = 1'b1;
	logic [2:0]  en_q = '0, inh_q = '0, trg_q = '0, cc = '0, flt = '0;
	logic [2:0]  en, inh, trg, sync, mode, on, fline, ev;
	logic        irq, awv = 0, wv = 0, bv, br = 0, arv = 0, rv, rr = 0, awr, wr, arr;
	logic [7:0]  awa = '0, ara = '0;
	logic [31:0] wd = '0, rd, d;
	logic [1:0]  bresp, rresp, r;
	int          err_count = 0, n_compared = 0, cyc = 0, evn = 0;
	// 25 MHz
	always #20 clk = ~clk;
	rucio_ext_ctrl #(.NCH(3)) i_rucio_ext_ctrl (.clk_i(clk), .en_req_i(en_q), .inh_req_i(inh_q), .trg_req_i(trg_q),
		.glitch_i(glitch), .en_o(en), .inh_o(inh), .trg_o(trg));
	// short pulse and filter keep the run brief
	rucio_top #(.NCH(3), .PULSE_LEN(PL), .FILT_LEN(3)) i_rucio_top (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce),
		.CHAN_OUTPUT_ENABLE_I(en), .CHAN_INHIBIT_CLOSED_I(inh), .CHAN_TRIGGER_I(trg), .CHAN_SYNC_PULSE_O(sync),
		.CHAN_REGULATION_MODE_O(mode), .CHAN_OUTPUT_ON_O(on), .CHAN_FAULT_LINE_O(fline), .CHAN_CC_MODE_I(cc),
		.CHAN_FAULT_I(flt), .CHAN_TRIGGER_EVENT_O(ev), .IRQ_O(irq), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara),
		.S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr));
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// watchdog and channel 0 trigger event tally
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (ev[0] === 1'b1)
			evn <= evn + 1;
		if (cyc == 2000) begin
			err_count++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// extra edge at the end so a following request never reassigns in the same step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
		end while (bv !== 1'b1);
		br <= 1'b0;
		@(posedge clk);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
		end while (rv !== 1'b1);
		v = rd;
		rs = rresp;
		rr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic t_onoff();
		inh_q <= 3'h7;
		wt(10);
		en_q <= 3'h7;
		wt(10);
		chk("on_en", on, 3'h7);
		chk("sync_hi", sync, 3'h7);
		wt(PL);
		chk("sync_lo", sync, 3'h0);
		en_q <= 3'h2;
		wt(10);
		chk("on_low", on, 3'h2);
		en_q <= 3'h7;
		wt(10);
		chk("on_again", on, 3'h7);
	endtask
	// inhibit shutdown latches until a command; the latch event drives the interrupt
	task automatic t_inhibit();
		inh_q <= 3'h6;
		wt(10);
		chk("on_inh", on, 3'h6);
		chk("irq_masked", irq, 1'b0);
		inh_q <= 3'h7;
		wt(10);
		chk("on_held", on, 3'h6);
		axi_wr(OFF_INT_MASK, 32'h0000_0100);
		chk("bresp_mask", bresp, RESP_OKAY);
		wt(1);
		chk("irq_set", irq, 1'b1);
		axi_rd(OFF_INT_STAT, d, r);
		chk("int_stat", d, 32'h0000_0100);
		chk("rresp_stat", r, RESP_OKAY);
		wt(1);
		chk("irq_clr", irq, 1'b0);
		axi_wr(OFF_CMD, 32'h0000_0001);
		wt(3);
		chk("on_cmd", on, 3'h7);
	endtask
	task automatic t_trigger();
		int e0;
		e0 = evn;
		glitch <= 1'b1;
		wt(1);
		glitch <= 1'b0;
		wt(10);
		chk("ev_glitch", evn - e0, 0);
		trg_q <= 3'h7;
		wt(15);
		trg_q <= 3'h0;
		wt(10);
		chk("ev_count", evn - e0, 1);
	endtask
	// clock enable low freezes the output; the channel enable register gates it
	task automatic t_freeze_ctrl();
		ce <= 1'b0;
		en_q <= 3'h5;
		wt(10);
		chk("on_frozen", on, 3'h7);
		ce <= 1'b1;
		wt(10);
		chk("on_thawed", on, 3'h5);
		axi_wr(OFF_CTRL, 32'h0000_0004);
		chk("bresp_ctrl", bresp, RESP_OKAY);
		wt(2);
		chk("on_gated", on, 3'h4);
		axi_rd(OFF_CTRL, d, r);
		chk("ctrl_rd", d, 32'h0000_0004);
	endtask
	task automatic t_status();
		cc <= 3'h5;
		flt <= 3'h2;
		wt(2);
		chk("mode", mode, 3'h5);
		chk("fault", fline, 3'h2);
		axi_rd(OFF_STATUS, d, r);
		chk("status", d, 32'h0205_0007);
		axi_rd(8'h40, d, r);
		chk("unmapped_resp", r, RESP_SLVERR);
		chk("unmapped_data", d, 32'h0);
	endtask
	initial begin
		wt(4);
		rst <= 1'b0;
		t_onoff();
		t_inhibit();
		t_trigger();
		t_status();
		t_freeze_ctrl();
		final_report();
	end
endmodule // rucio_top_tb_top
